//--- rtl/uio_cond_defines.svh
// Register offsets, field positions, reset values and timing counts of the user I/O block
`ifndef UIO_COND_DEFINES_SVH
`define UIO_COND_DEFINES_SVH

// Byte offsets on the register bus
`define OFS_CMD    5'h00
`define OFS_JUMP   5'h04
`define OFS_HOLD   5'h08
`define OFS_STATUS 5'h0c
`define OFS_MODE   5'h10
`define OFS_INPUT  5'h14
`define OFS_OUTPUT 5'h18

// Command word fields
`define F_OP   2:0
`define F_PTA  8:3
`define F_LVLA 9
`define F_PTB  15:10
`define F_LVLB 16
`define F_HASB 17
`define F_JMP  18
`define F_HOLD 19

// Mode word fields
`define F_MANUAL 0
`define F_U1PT   13:8
`define F_U2PT   21:16

// Status word bits
`define ST_BUSY   0
`define ST_DONE   1
`define ST_JUMPED 2
`define ST_REJ    3

// Reset values: user 1 on point 1, user 2 on point 2, every output high impedance
`define RST_MODE 32'h0002_0100
`define RST_OUT  32'hffff_ffff

// Limits
`define POINT_MAX   6'h20
`define HOLD_MAX_MS 32'h0098_967f

// Hold-time tick
`define CLK_HZ           40000000
`define HOLD_TICK_US     1000
`define HOLD_TICK_CYCLES (`CLK_HZ / 1000000 * `HOLD_TICK_US)

`endif

//--- rtl/uio_cond_pkg.sv
// Types shared by the user I/O condition block
package uio_cond_pkg;
	typedef enum logic [2:0] {
		user1_valid_check,
		user1_invalid_check,
		user2_valid_check,
		user2_invalid_check,
		input_condition_cmd,
		output_control_cmd,
		output_state_condition_cmd
	} cmd_op_t;

	typedef enum logic [2:0] {
		st_idle,
		st_wait,
		st_hold,
		st_wait_in,
		st_finish
	} exec_state_t;
endpackage

//--- rtl/user_io_condition_control.sv
// User I/O condition command executor with Avalon-MM register access
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`include "uio_cond_defines.svh"

// Contract
// - User check without jump waits while the input matches, advances once it does not.
// - User check with jump jumps on match, else advances without waiting.
// - Valid check, no jump: stall while input valid, release when invalid.
// - Invalid check, no jump: stall while input invalid, release when valid.
// - Valid check with jump: jump when valid, else next block.
// - Invalid check with jump: jump when invalid, else next block.
// - Operands are inputs, outputs, output states; 0 conducts, 1 is high impedance.
// - Point numbers select pins and are accepted only from 1 to 32.
// - Level suffix 0 means low, 1 high; absent means low.
// - Hold time in seconds up to 9999.999; absent means held forever.
// - Output control drives the pin, cancels it after the hold time.
// - Output control naming an input drives, then waits for that input.
// - Manual mode accepts only output forms without input checks.
// - Input condition waits for the level, then advances.
// - Input condition with jump branches on match, else advances at once.
// - Input condition with output waits, drives, optionally holds, then continues.
// - Output-state condition tests an output pin, else like input condition.
// - Output-state condition with output drives it once met, waits otherwise.
module user_io_condition_control #(
	parameter int unsigned MS_CYCLES = `HOLD_TICK_CYCLES
) (
	input  wire logic        clk_sys_in,
	input  wire logic        resetn_in,
	input  wire logic [4:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	input  wire logic [31:0] user_input_pin_in,
	output logic      [31:0] user_output_pin_out,
	output logic      [31:0] user_output_pin_oe_out,
	output logic             advance_out,
	output logic             jump_out,
	output logic      [15:0] jump_target_out,
	output logic             busy_out
);
	import uio_cond_pkg::*;

	localparam int DIVW = $clog2(MS_CYCLES + 1);

	logic [31:0] in_meta_q;
	logic [31:0] in_sync_q;
	logic [31:0] out_q;
	logic [31:0] cmd_q;
	logic [31:0] jmp_q;
	logic [31:0] hold_q;
	logic [31:0] mode_q;
	logic        ack_q;
	logic        done_q;
	logic        rej_q;
	logic        jumped_q;
	logic        res_q;
	logic        save_q;
	logic [4:0]  hold_pt_q;
	logic [23:0] hold_cnt_q;
	logic [DIVW-1:0] div_q;
	exec_state_t st_q;

	logic [31:0] wmask;
	logic [31:0] new_cmd;
	logic        acc_w;
	logic        wr_cmd;
	logic        cmd_ok;
	logic        cmd_go;
	logic        tick;
	logic        cond_a;
	logic        cond_b;
	logic        release_a;
	cmd_op_t     op_q;
	cmd_op_t     n_op;

	// Point number to pin index; points count from one
	function automatic logic [4:0] pidx(input logic [5:0] p);
		logic [5:0] d;
		d = p - 6'h01;
		return d[4:0];
	endfunction

	// A point is usable only inside the pin range
	function automatic logic pok(input logic [5:0] p);
		return (p != 6'h00) && (p <= `POINT_MAX);
	endfunction

	// Point that a user check looks at, taken from the mode word
	function automatic logic [5:0] user_pt(input logic [2:0] op, input logic [31:0] mode);
		return op[1] ? mode[`F_U2PT] : mode[`F_U1PT];
	endfunction

	// Primary condition of a command word; user checks compare against valid (low)
	// or invalid (high), the others against their own level suffix
	function automatic logic cond_of(input logic [31:0] c, input logic [31:0] pins,
			input logic [31:0] outs, input logic [31:0] mode);
		logic [2:0] op;
		logic [5:0] pt;
		logic       lvl;
		op  = c[`F_OP];
		pt  = (op < 3'h4) ? user_pt(op, mode) : c[`F_PTA];
		lvl = (op < 3'h4) ? op[0] : c[`F_LVLA];
		if (op == 3'(output_state_condition_cmd))
			return outs[pidx(pt)] == lvl;
		return pins[pidx(pt)] == lvl;
	endfunction

	// Command word legality, judged when the word is written
	function automatic logic cmd_ok_of(input logic [31:0] c, input logic [31:0] mode,
			input logic [31:0] hold);
		logic [2:0] op;
		logic       ok;
		op = c[`F_OP];
		ok = (op != 3'h7);
		if (op < 3'h4)
			ok = ok && pok(user_pt(op, mode));
		else
			ok = ok && pok(c[`F_PTA]) && (!c[`F_HASB] || pok(c[`F_PTB]));
		if (mode[`F_MANUAL] && (op != 3'(output_control_cmd) || c[`F_HASB]))
			ok = 1'b0;
		if (op >= 3'h4 && c[`F_HOLD] && hold > `HOLD_MAX_MS)
			ok = 1'b0;
		return ok;
	endfunction

	// Byte enables widened to a bit mask
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{avs_byteenable_in[i]}};
		end
	end

	// Bus decode; a write takes effect on the edge that sees waitrequest low
	assign acc_w   = avs_write_in && ack_q;
	assign wr_cmd  = acc_w && (avs_address_in == `OFS_CMD);
	assign new_cmd = (cmd_q & ~wmask) | (avs_writedata_in & wmask);
	assign cmd_ok  = cmd_ok_of(new_cmd, mode_q, hold_q);
	assign cmd_go  = wr_cmd && cmd_ok && (st_q == st_idle);
	assign n_op    = cmd_op_t'(new_cmd[`F_OP]);
	assign op_q    = cmd_op_t'(cmd_q[`F_OP]);
	// Conditions are re-evaluated every cycle from the synchronised pins, or from out_q for output-state checks
	assign cond_a    = cond_of(cmd_q, in_sync_q, out_q, mode_q);
	assign cond_b    = in_sync_q[pidx(cmd_q[`F_PTB])] == cmd_q[`F_LVLB];
	// User checks release on the opposite of the tested state
	assign release_a = (cmd_q[`F_OP] < 3'h4) ? !cond_a : cond_a;
	// One answer cycle: waitrequest stays high for the first cycle of any request
	assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_q;
	assign busy_out            = (st_q != st_idle);
	assign user_output_pin_out = 32'h0000_0000;
	// Open-drain: only a conducting (0) point is driven
	assign user_output_pin_oe_out = ~out_q;
	assign tick = (div_q == DIVW'(MS_CYCLES - 1));

	// Two-stage synchroniser for the user inputs
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			in_meta_q <= 32'h0000_0000;
			in_sync_q <= 32'h0000_0000;
		end else begin
			in_meta_q <= user_input_pin_in;
			in_sync_q <= in_meta_q;
		end
	end

	// Bus answer strobe
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in)
			ack_q <= 1'b0;
		else
			ack_q <= (avs_read_in || avs_write_in) && !ack_q;
	end

	// Read data are captured in the waitrequest cycle and stand at the taking edge
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			avs_readdata_out <= 32'h0000_0000;
		end else if (avs_read_in && !ack_q) begin
			case (avs_address_in)
				`OFS_CMD:    avs_readdata_out <= cmd_q;
				`OFS_JUMP:   avs_readdata_out <= {16'h0000, jmp_q[15:0]};
				`OFS_HOLD:   avs_readdata_out <= {8'h00, hold_q[23:0]};
				`OFS_STATUS: avs_readdata_out <= {28'h0000000, rej_q, jumped_q, done_q, busy_out};
				`OFS_MODE:   avs_readdata_out <= mode_q & 32'h003f_3f01;
				`OFS_INPUT:  avs_readdata_out <= in_sync_q;
				`OFS_OUTPUT: avs_readdata_out <= out_q;
				default:     avs_readdata_out <= 32'h0000_0000;
			endcase
		end
	end

	// Software registers; the command word is frozen while a command runs
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cmd_q  <= 32'h0000_0000;
			jmp_q  <= 32'h0000_0000;
			hold_q <= 32'h0000_0000;
			mode_q <= `RST_MODE;
		end else if (acc_w && st_q == st_idle) begin
			case (avs_address_in)
				`OFS_CMD:  cmd_q  <= new_cmd;
				`OFS_JUMP: jmp_q  <= (jmp_q & ~wmask) | (avs_writedata_in & wmask);
				`OFS_HOLD: hold_q <= (hold_q & ~wmask) | (avs_writedata_in & wmask);
				`OFS_MODE: mode_q <= (mode_q & ~wmask) | (avs_writedata_in & wmask);
				default:   ;
			endcase
		end
	end

	// Sticky flags; a new event wins over a write-one clear in the same cycle
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			done_q <= 1'b0;
			rej_q  <= 1'b0;
		end else begin
			if (st_q == st_finish)
				done_q <= 1'b1;
			else if (acc_w && avs_address_in == `OFS_STATUS && avs_writedata_in[`ST_DONE]
					&& avs_byteenable_in[0])
				done_q <= 1'b0;
			if (wr_cmd && !cmd_go)
				rej_q <= 1'b1;
			else if (acc_w && avs_address_in == `OFS_STATUS && avs_writedata_in[`ST_REJ]
					&& avs_byteenable_in[0])
				rej_q <= 1'b0;
		end
	end

	// Millisecond divider, restarted at each hold so the first tick is a full step
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in)
			div_q <= '0;
		else if (st_q != st_hold || tick)
			div_q <= '0;
		else
			div_q <= div_q + DIVW'(1);
	end

	// Command execution, output points and sequencer answer
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_q            <= st_idle;
			out_q           <= `RST_OUT;
			res_q           <= 1'b0;
			jumped_q        <= 1'b0;
			save_q          <= 1'b1;
			hold_pt_q       <= 5'h00;
			hold_cnt_q      <= 24'h000000;
			advance_out     <= 1'b0;
			jump_out        <= 1'b0;
			jump_target_out <= 16'h0000;
		end else begin
			advance_out <= 1'b0;
			jump_out    <= 1'b0;
			case (st_q)
				st_idle: begin
					if (cmd_go) begin
						hold_cnt_q <= hold_q[23:0];
						if (n_op == output_control_cmd) begin
							out_q[pidx(new_cmd[`F_PTA])] <= new_cmd[`F_LVLA];
							save_q    <= out_q[pidx(new_cmd[`F_PTA])];
							hold_pt_q <= pidx(new_cmd[`F_PTA]);
							res_q     <= 1'b0;
							if (new_cmd[`F_HOLD])
								st_q <= st_hold;
							else if (new_cmd[`F_HASB])
								st_q <= st_wait_in;
							else
								st_q <= st_finish;
						end else if (new_cmd[`F_JMP]) begin
							// Branch decided at once, no waiting
							res_q <= cond_of(new_cmd, in_sync_q, out_q, mode_q);
							st_q  <= st_finish;
						end else begin
							st_q <= st_wait;
						end
					end
				end
				st_wait: begin
					if (release_a) begin
						res_q <= 1'b0;
						if (op_q >= input_condition_cmd && cmd_q[`F_HASB]) begin
							out_q[pidx(cmd_q[`F_PTB])] <= cmd_q[`F_LVLB];
							save_q    <= out_q[pidx(cmd_q[`F_PTB])];
							hold_pt_q <= pidx(cmd_q[`F_PTB]);
							st_q      <= cmd_q[`F_HOLD] ? st_hold : st_finish;
						end else begin
							st_q <= st_finish;
						end
					end
				end
				st_hold: begin
					if (hold_cnt_q == 24'h000000) begin
						out_q[hold_pt_q] <= save_q;
						if (op_q == output_control_cmd && cmd_q[`F_HASB])
							st_q <= st_wait_in;
						else
							st_q <= st_finish;
					end else if (tick) begin
						hold_cnt_q <= hold_cnt_q - 24'h000001;
					end
				end
				st_wait_in: begin
					if (cond_b)
						st_q <= st_finish;
				end
				st_finish: begin
					advance_out     <= !res_q;
					jump_out        <= res_q;
					jump_target_out <= res_q ? jmp_q[15:0] : 16'h0000;
					jumped_q        <= res_q;
					st_q            <= st_idle;
				end
				default: st_q <= st_idle;
			endcase
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	sequence s_jump_launch;
		cmd_go && new_cmd[`F_JMP] && n_op != output_control_cmd;
	endsequence
	sequence s_hold_expire;
		st_q == st_hold && hold_cnt_q == 24'h000000;
	endsequence
	a_manual_reject: assert property (
		wr_cmd && st_q == st_idle && mode_q[`F_MANUAL] && new_cmd[`F_HASB] |=> rej_q && !busy_out)
		else $error("manual input-check form was accepted");
	a_point_range: assert property (
		wr_cmd && !busy_out && new_cmd[`F_OP] >= 3'h4 && new_cmd[`F_PTA] > `POINT_MAX
			|=> !busy_out && rej_q)
		else $error("out-of-range point was accepted");
	a_user_stall: assert property (
		st_q == st_wait && cmd_q[`F_OP] < 3'h4 && cond_a |=> st_q == st_wait && !advance_out)
		else $error("user check released while tested state held");
	a_wait_release: assert property (
		st_q == st_wait && release_a && !cmd_q[`F_HASB] |=> ##1 advance_out && !busy_out)
		else $error("met condition did not advance within two cycles");
	a_jump_decide: assert property (
		s_jump_launch ##0 cond_of(new_cmd, in_sync_q, out_q, mode_q) |=> ##1 jump_out
			&& jump_target_out == jmp_q[15:0])
		else $error("matching branch did not jump to target");
	a_no_jump: assert property (
		s_jump_launch ##0 !cond_of(new_cmd, in_sync_q, out_q, mode_q) |=> ##1 advance_out
			&& !jump_out)
		else $error("unmatched branch did not advance");
	a_out_drive: assert property (
		cmd_go && n_op == output_control_cmd |=> out_q[hold_pt_q] == cmd_q[`F_LVLA])
		else $error("output point not driven to commanded level");
	a_hold_steady: assert property (
		st_q == st_hold && hold_cnt_q != 24'h000000 |=> $stable(out_q))
		else $error("output moved during hold");
	a_hold_cancel: assert property (
		s_hold_expire ##0 save_q |=> user_output_pin_oe_out[hold_pt_q] == 1'b0)
		else $error("held output not cancelled");
	a_state_drive: assert property (
		st_q == st_wait && op_q == output_state_condition_cmd && release_a && cmd_q[`F_HASB]
			|=> out_q[pidx(cmd_q[`F_PTB])] == cmd_q[`F_LVLB])
		else $error("output-state condition did not drive its output");
	a_in_wait: assert property (
		st_q == st_wait_in && !cond_b |=> st_q == st_wait_in)
		else $error("progress before named input reached its level");
endmodule

//--- verification/tb.sv
// Self-checking bench for the user I/O condition block
`timescale 1ns/1ps
`include "uio_cond_defines.svh"
`define CHK(nm, ex, got) begin \
	checks_done++; \
	if ((got) !== (ex)) begin \
		n_mismatch++; \
		$display("wrong value %s expected %h seen %h", nm, ex, got); \
	end \
end
module tb;
	import uio_cond_pkg::*;
	// Short millisecond tick keeps hold tests brief
	localparam int unsigned MS = 4;
	logic        clk_sys_in;
	logic        resetn_in;
	logic [4:0]  avs_address_in;
	logic        avs_read_in;
	logic        avs_write_in;
	logic [31:0] avs_writedata_in;
	logic [3:0]  avs_byteenable_in;
	logic [31:0] avs_readdata_out;
	logic        avs_waitrequest_out;
	logic [31:0] user_input_pin_in;
	logic [31:0] user_output_pin_out;
	logic [31:0] user_output_pin_oe_out;
	logic        advance_out;
	logic        jump_out;
	logic [15:0] jump_target_out;
	logic        busy_out;
	logic [31:0] switch_closed;
	logic [31:0] load_on;
	int          n_mismatch;
	int          checks_done;

	user_io_condition_control #(.MS_CYCLES(MS)) user_io_condition_control_inst (
		.clk_sys_in, .resetn_in, .avs_address_in, .avs_read_in, .avs_write_in,
		.avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
		.user_input_pin_in, .user_output_pin_out, .user_output_pin_oe_out,
		.advance_out, .jump_out, .jump_target_out, .busy_out);

	uio_field_model uio_field_model_inst (
		.switch_closed_in(switch_closed), .user_output_pin_in(user_output_pin_out),
		.user_output_pin_oe_in(user_output_pin_oe_out),
		.user_input_pin_out(user_input_pin_in), .load_on_out(load_on));

	// 40 MHz system clock
	initial begin
		clk_sys_in = 1'b0;
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end

	// Prints the counts and the verdict, then stops the run
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// One Avalon transfer; request held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		@(posedge clk_sys_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= wr;
		avs_read_in <= ~wr;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 20);
		q = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		if (avs_waitrequest_out !== 1'b0) begin
			n_mismatch++;
			finish_test();
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	// Masked read compare
	task automatic rdchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] ex,
			input string nm);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		`CHK(nm, ex, q & m)
	endtask

	// Command word: hold, jump, B present, level B, point B, level A, point A, op
	function automatic logic [31:0] cmd(input cmd_op_t op, input logic [5:0] pa,
			input logic la, input logic [5:0] pb, input logic lb, input logic hb,
			input logic hj, input logic hh);
		return {12'h0, hh, hj, hb, lb, pb, la, pa, op};
	endfunction

	task automatic go(input logic [31:0] w);
		wr(`OFS_CMD, w);
	endtask

	// Watches for the sequencer answer {jump, advance} within a bounded window
	task automatic ans(input int bound, input logic [1:0] ex, input string nm);
		logic [1:0] got;
		got = 2'b00;
		for (int i = 0; i < bound && got === 2'b00; i++) begin
			@(posedge clk_sys_in);
			got = {jump_out, advance_out};
		end
		`CHK(nm, ex, got)
		if (ex != 2'b00 && got === 2'b00) begin
			finish_test();
		end
	endtask

	// Switch changes land just after an edge, like a real synchronised pin
	task automatic sw(input logic [31:0] v);
		@(posedge clk_sys_in);
		switch_closed <= v;
	endtask

	initial begin
		logic [5:0] p;
		n_mismatch = 0;
		checks_done = 0;
		resetn_in = 1'b0;
		avs_address_in = 5'h00;
		avs_read_in = 1'b0;
		avs_write_in = 1'b0;
		avs_writedata_in = 32'h0;
		avs_byteenable_in = 4'hf;
		switch_closed = 32'h0;
		repeat (8) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		@(posedge clk_sys_in);
		`CHK("oe reset", 32'h0, user_output_pin_oe_out)
		`CHK("od data", 32'h0, user_output_pin_out)
		rdchk(`OFS_MODE, 32'hffffffff, `RST_MODE, "mode");
		rdchk(`OFS_OUTPUT, 32'hffffffff, `RST_OUT, "output");
		rdchk(5'h1c, 32'hffffffff, 32'h0, "unmapped");
		// First and last point driven low, then released
		for (int i = 0; i < 2; i++) begin
			p = i ? 6'h20 : 6'h01;
			go(cmd(output_control_cmd, p, 1'b0, 6'h0, 1'b0, 1'b0, 1'b0, 1'b0));
			ans(10, 2'b01, "drive");
			`CHK("oe low", 1'b1, user_output_pin_oe_out[p-1])
			`CHK("load", 1'b1, load_on[p-1])
			go(cmd(output_control_cmd, p, 1'b1, 6'h0, 1'b0, 1'b0, 1'b0, 1'b0));
			ans(10, 2'b01, "release");
			`CHK("oe high", 1'b0, user_output_pin_oe_out[p-1])
		end
		// Points just outside the range are refused with no answer
		for (int i = 0; i < 2; i++) begin
			p = i ? 6'h21 : 6'h00;
			go(cmd(output_control_cmd, p, 1'b0, 6'h0, 1'b0, 1'b0, 1'b0, 1'b0));
			ans(10, 2'b00, "bad point");
			rdchk(`OFS_STATUS, 32'h8, 32'h8, "rejected");
			wr(`OFS_STATUS, 32'ha);
		end
		// Timed hold of 2 ms, then the previous level returns
		wr(`OFS_HOLD, 32'h2);
		go(cmd(output_control_cmd, 6'h05, 1'b0, 6'h0, 1'b0, 1'b0, 1'b0, 1'b1));
		ans(4, 2'b00, "hold early");
		`CHK("oe hold", 1'b1, user_output_pin_oe_out[4])
		ans(2 * MS + 10, 2'b01, "hold end");
		@(posedge clk_sys_in);
		`CHK("oe restored", 1'b0, user_output_pin_oe_out[4])
		// Drive then wait on an input point
		go(cmd(output_control_cmd, 6'h06, 1'b0, 6'h09, 1'b0, 1'b1, 1'b0, 1'b0));
		ans(20, 2'b00, "wait in");
		`CHK("oe b", 1'b1, user_output_pin_oe_out[5])
		`CHK("busy wait", 1'b1, busy_out)
		sw(32'h100);
		ans(10, 2'b01, "in met");
		`CHK("busy idle", 1'b0, busy_out)
		// User checks without a target stall until the state flips
		sw(32'h101);
		go(cmd(user1_valid_check, 6'h0, 1'b0, 6'h0, 1'b0, 1'b0, 1'b0, 1'b0));
		ans(20, 2'b00, "valid stall");
		sw(32'h100);
		ans(10, 2'b01, "valid free");
		go(cmd(user2_invalid_check, 6'h0, 1'b0, 6'h0, 1'b0, 1'b0, 1'b0, 1'b0));
		ans(20, 2'b00, "invalid stall");
		sw(32'h102);
		ans(10, 2'b01, "invalid free");
		// With a target: user 1 valid, user 2 invalid
		wr(`OFS_JUMP, 32'h1234);
		sw(32'h101);
		for (int i = 0; i < 4; i++) begin
			go(cmd(cmd_op_t'(i), 6'h0, 1'b0, 6'h0, 1'b0, 1'b0, 1'b1, 1'b0));
			ans(10, (i == 0 || i == 3) ? 2'b10 : 2'b01, "user jump");
		end
		`CHK("target", 16'h1234, jump_target_out)
		rdchk(`OFS_STATUS, 32'h7, 32'h6, "status jump");
		// Only the low byte lane of the target is rewritten
		avs_byteenable_in <= 4'h1;
		wr(`OFS_JUMP, 32'h0000_5678);
		avs_byteenable_in <= 4'hf;
		rdchk(`OFS_JUMP, 32'hffffffff, 32'h0000_1278, "jump bytes");
		rdchk(`OFS_INPUT, 32'h101, 32'h0, "input pins");
		// Input condition on point 9, which reads low
		go(cmd(input_condition_cmd, 6'h09, 1'b1, 6'h0, 1'b0, 1'b0, 1'b1, 1'b0));
		ans(10, 2'b01, "in miss");
		go(cmd(input_condition_cmd, 6'h09, 1'b0, 6'h0, 1'b0, 1'b0, 1'b1, 1'b0));
		ans(10, 2'b10, "in hit");
		`CHK("target b", 16'h1278, jump_target_out)
		go(cmd(input_condition_cmd, 6'h09, 1'b0, 6'h14, 1'b0, 1'b1, 1'b0, 1'b0));
		ans(10, 2'b01, "in drive");
		`CHK("oe 20", 1'b1, user_output_pin_oe_out[19])
		// Output state of point 20 (low) and point 22 (high impedance)
		go(cmd(output_state_condition_cmd, 6'h14, 1'b0, 6'h0, 1'b0, 1'b0, 1'b1, 1'b0));
		ans(10, 2'b10, "state hit");
		go(cmd(output_state_condition_cmd, 6'h14, 1'b0, 6'h15, 1'b0, 1'b1, 1'b0, 1'b0));
		ans(10, 2'b01, "state drive");
		`CHK("oe 21", 1'b1, user_output_pin_oe_out[20])
		go(cmd(output_state_condition_cmd, 6'h16, 1'b0, 6'h0, 1'b0, 1'b0, 1'b1, 1'b0));
		ans(10, 2'b01, "state miss");
		// Manual mode refuses the forms that check inputs
		wr(`OFS_MODE, `RST_MODE | 32'h1);
		wr(`OFS_STATUS, 32'ha);
		go(cmd(input_condition_cmd, 6'h09, 1'b0, 6'h0, 1'b0, 1'b0, 1'b0, 1'b0));
		ans(10, 2'b00, "manual in");
		rdchk(`OFS_STATUS, 32'h8, 32'h8, "manual rej");
		go(cmd(output_control_cmd, 6'h07, 1'b0, 6'h09, 1'b0, 1'b1, 1'b0, 1'b0));
		ans(10, 2'b00, "manual b");
		go(cmd(output_control_cmd, 6'h07, 1'b0, 6'h0, 1'b0, 1'b0, 1'b0, 1'b0));
		ans(10, 2'b01, "manual out");
		finish_test();
	end
endmodule

//--- verification/uio_field_model.sv
// Field model: user input switches with pull-ups and open-drain output loads
`timescale 1ns/1ps
module uio_field_model (
	input  wire logic [31:0] switch_closed_in,
	input  wire logic [31:0] user_output_pin_in,
	input  wire logic [31:0] user_output_pin_oe_in,
	output logic      [31:0] user_input_pin_out,
	output logic      [31:0] load_on_out
);
	// A closed switch ties the point to 0V; an open one floats up to the pull-up
	assign user_input_pin_out = ~switch_closed_in;
	// A load only draws current through a pin that is driven low
	assign load_on_out = user_output_pin_oe_in & ~user_output_pin_in;
endmodule
